//--- core/otrn_pkg.sv
// Purpose: shared constants for the oscillator training block
// Assumes: 10 MHz block clock standing in for the internal oscillator
// Notes: period code tables map each field code to a period in microseconds
package otrn_pkg;
  // clock and training interval
  localparam int CLK_HZ = 10_000_000;
  localparam int TRAIN_US = 4000;
  localparam int EXP_CYC = (CLK_HZ / 1_000_000) * TRAIN_US;
  // accepted range for the command-and-response period, in microseconds
  localparam int CRM_MIN_US = 500;
  localparam int CRM_MAX_US = 4000;
  // period field codes to microseconds
  localparam int CRM_US [4] = '{500, 1000, 2000, 4000};
  localparam int PERIODIC_COLLECTION_MODE_US [8] = '{250, 500, 1000, 2000, 4000, 300, 800, 1500};
  // APB byte offsets
  localparam logic [7:0] CFG_OFF = 8'h00;
  localparam logic [7:0] STAT_OFF = 8'h04;
  localparam logic [7:0] MASK_OFF = 8'h08;
  localparam logic [7:0] TRIM_OFF = 8'h0C;
  localparam logic [7:0] MEAS_OFF = 8'h10;
  // configuration field positions
  localparam int EN_BIT = 0;
  localparam int REV_BIT = 1;
  localparam int CRM_LSB = 2;
  localparam int PERIODIC_COLLECTION_MODE_LSB = 4;
  localparam logic [6:0] CFG_RST = 7'h00;
  // status bit positions
  localparam int EV_MEAS = 0;
  localparam int EV_ADJ = 1;
  localparam int EV_FAIL = 2;
  localparam int EV_N = 3;
  localparam logic [2:0] MASK_RST = 3'h0;
  // error filter
  localparam logic [6:0] ERR_SET = 7'h40;
  localparam logic [6:0] ERR_MAX = 7'h7F;
  // default comparison figures
  localparam int WIN_DEF = 2000;
  localparam int DEAD_DEF = 20;
  localparam int STEP_DEF = 1;
  // training state
  typedef enum logic [0:0] {
    OTRN_IDLE = 1'b0,
    OTRN_RUN = 1'b1
  } otrn_state_type;
endpackage

//--- core/otrn_cmp.sv
// Purpose: window and deadband check of one measured interval
// Assumes: measured and expected counts are unsigned, same width
// Notes: results are registered and valid with the done pulse
`timescale 1ns/1ns
`default_nettype none
module otrn_cmp #(
  parameter int W = 20,
  parameter int WIN = 2000,
  parameter int DEAD = 20
) (
  input wire logic clk, // block clock
  input wire logic rst, // synchronous reset, high
  input wire logic start, // one-cycle request to compare
  input wire logic [W-1:0] meas, // measured cycle count
  input wire logic [W-1:0] expct, // expected cycle count
  output logic done, // result valid pulse
  output logic in_win, // measurement inside the window
  output logic go_up, // raise the target
  output logic go_down // lower the target
);
  logic [W:0] hi_win;
  logic [W:0] lo_win;
  logic [W:0] hi_dead;
  logic [W:0] lo_dead;
  logic [W:0] m_ext;

  ////////////////////////////////////////////////////////////////////
  // bounds widened by one bit so the sums cannot wrap
  assign m_ext = {1'b0, meas};
  assign hi_win = {1'b0, expct} + (W+1)'(WIN);
  assign lo_win = {1'b0, expct} - (W+1)'(WIN);
  assign hi_dead = {1'b0, expct} + (W+1)'(DEAD);
  assign lo_dead = {1'b0, expct} - (W+1)'(DEAD);

  ////////////////////////////////////////////////////////////////////
  // registered verdict
  always_ff @(posedge clk) begin
    if (rst) begin
      done <= 1'b0;
      in_win <= 1'b0;
      go_up <= 1'b0;
      go_down <= 1'b0;
    end else begin
      done <= start;
      if (start) begin
        in_win <= (m_ext <= hi_win) && (m_ext >= lo_win || lo_win[W]);
        go_down <= m_ext > hi_dead;
        go_up <= (m_ext < lo_dead) && !lo_dead[W];
      end
    end
  end
endmodule
`default_nettype wire

//--- core/otrn_top.sv
// Purpose: oscillator trim by measuring the master's command timing
// Assumes: command and blocking-end pulses are synchronous to CLK
// Notes: registers on APB, read-to-clear status, one level interrupt
`timescale 1ns/1ns
`default_nettype none
module otrn_top #(
  parameter int EXP_CYC = otrn_pkg::EXP_CYC,
  parameter int WIN = otrn_pkg::WIN_DEF,
  parameter int DEAD = otrn_pkg::DEAD_DEF,
  parameter int STEP = otrn_pkg::STEP_DEF,
  parameter int TRIM_W = 8,
  parameter int MEAS_W = 20
) (
  input wire logic CLK, // block clock, 10 MHz
  input wire logic RST, // synchronous reset, high
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb access phase
  input wire logic PWRITE, // apb write
  input wire logic [7:0] PADDR, // apb byte address
  input wire logic [31:0] PWDATA, // apb write data
  output logic [31:0] PRDATA, // apb read data
  output logic PREADY, // apb ready
  output logic PSLVERR, // apb error on unmapped address
  input wire logic CMD_PULSE, // one pulse per master command or sync
  input wire logic BLOCK_END, // end of command blocking time
  input wire logic PERIODIC_MODE, // high: periodic collection mode
  input wire logic PROTO_PSI5, // high: psi5 protocol, else dsi3
  output logic signed [TRIM_W-1:0] TRIM_OFFSET, // frequency target offset
  output logic TRIM_FAIL, // training failure flag
  output logic IRQ // interrupt, level
);
  logic [6:0] cfg_r;
  logic [otrn_pkg::EV_N-1:0] stat_r;
  logic [otrn_pkg::EV_N-1:0] mask_r;
  logic [otrn_pkg::EV_N-1:0] ev;
  logic signed [TRIM_W-1:0] trim_r;
  logic signed [TRIM_W-1:0] trim_nxt;
  logic [otrn_pkg::EV_N-1:0] stat_nxt;
  logic [MEAS_W-1:0] cyc_r;
  logic [MEAS_W-1:0] meas_r;
  logic [7:0] per_r;
  logic [7:0] n_per;
  logic [6:0] err_r;
  logic fail_r;
  logic began_r;
  logic pend_r;
  logic pend_up_r;
  logic en_d_r;
  logic crm_ok;
  logic use_periodic_collection_mode;
  logic active;
  logic close_int;
  logic cmp_done;
  logic cmp_win;
  logic cmp_up;
  logic cmp_dn;
  logic wr;
  logic rd;
  logic hit;
  logic [MEAS_W-1:0] exp_w;
  otrn_pkg::otrn_state_type state_r;

  // step and range ends, all signed so trim compares stay signed
  localparam logic signed [TRIM_W-1:0] step_s = TRIM_W'(STEP);
  localparam logic signed [TRIM_W-1:0] trim_hi = {1'b0, {(TRIM_W-1){1'b1}}};
  localparam logic signed [TRIM_W-1:0] trim_lo = {1'b1, {(TRIM_W-1){1'b0}}};

  ////////////////////////////////////////////////////////////////////
  // derived periods per interval and range check
  always_comb begin
    int us;
    us = 0;
    if (use_periodic_collection_mode) begin
      us = otrn_pkg::PERIODIC_COLLECTION_MODE_US[cfg_r[otrn_pkg::PERIODIC_COLLECTION_MODE_LSB +: 3]];
    end else begin
      us = otrn_pkg::CRM_US[cfg_r[otrn_pkg::CRM_LSB +: 2]];
    end
    n_per = 8'(otrn_pkg::TRAIN_US / us);
    crm_ok = (us >= otrn_pkg::CRM_MIN_US) && (us <= otrn_pkg::CRM_MAX_US)
             && ((otrn_pkg::TRAIN_US % us) == 0);
  end

  // psi5 only has periodic sync pulses, so it always uses that field
  assign use_periodic_collection_mode = PERIODIC_MODE || PROTO_PSI5;
  assign active = cfg_r[otrn_pkg::EN_BIT] && (use_periodic_collection_mode || crm_ok);
  assign close_int = (state_r == otrn_pkg::OTRN_RUN) && CMD_PULSE
                     && (per_r + 8'h01 >= n_per);
  assign exp_w = MEAS_W'(EXP_CYC);

  ////////////////////////////////////////////////////////////////////
  // apb decode, zero wait states
  assign wr = PSEL && PENABLE && PWRITE;
  assign rd = PSEL && PENABLE && !PWRITE;
  assign hit = (PADDR == otrn_pkg::CFG_OFF) || (PADDR == otrn_pkg::STAT_OFF)
               || (PADDR == otrn_pkg::MASK_OFF) || (PADDR == otrn_pkg::TRIM_OFF)
               || (PADDR == otrn_pkg::MEAS_OFF);
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !hit;

  // configuration register
  always_ff @(posedge CLK) begin
    if (RST) begin
      cfg_r <= otrn_pkg::CFG_RST;
    end else if (wr && PADDR == otrn_pkg::CFG_OFF) begin
      cfg_r <= PWDATA[6:0];
    end
  end

  // mask register
  always_ff @(posedge CLK) begin
    if (RST) begin
      mask_r <= otrn_pkg::MASK_RST;
    end else if (wr && PADDR == otrn_pkg::MASK_OFF) begin
      mask_r <= PWDATA[otrn_pkg::EV_N-1:0];
    end
  end

  // read data register
  always_ff @(posedge CLK) begin
    if (RST) begin
      PRDATA <= 32'h0000_0000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      unique case (PADDR)
        otrn_pkg::CFG_OFF: PRDATA <= {25'h0, cfg_r};
        otrn_pkg::STAT_OFF: PRDATA <= {29'h0, stat_r};
        otrn_pkg::MASK_OFF: PRDATA <= {29'h0, mask_r};
        otrn_pkg::TRIM_OFF: PRDATA <= {16'h0, 1'b0, err_r,
                                      8'(trim_r)};
        otrn_pkg::MEAS_OFF: PRDATA <= 32'(meas_r);
        default: PRDATA <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // sticky status, cleared by a read, a new event wins
  always_ff @(posedge CLK) begin
    if (RST) begin
      stat_r <= '0;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  // a read clears only the bits it returned, so an event landing
  // in the setup cycle survives into the next read
  always_comb begin
    stat_nxt = stat_r | ev;
    if (rd && PADDR == otrn_pkg::STAT_OFF) begin
      stat_nxt = (stat_r & ~PRDATA[otrn_pkg::EV_N-1:0]) | ev;
    end
  end

  assign IRQ = |(stat_r & mask_r);

  ////////////////////////////////////////////////////////////////////
  // interval sequencer: open on a command, close after n periods
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_r <= otrn_pkg::OTRN_IDLE;
    end else if (!active) begin
      state_r <= otrn_pkg::OTRN_IDLE;
    end else begin
      unique case (state_r)
        otrn_pkg::OTRN_IDLE: if (CMD_PULSE) state_r <= otrn_pkg::OTRN_RUN;
        otrn_pkg::OTRN_RUN: state_r <= otrn_pkg::OTRN_RUN;
      endcase
    end
  end

  // period counter, restarts at each closing command
  always_ff @(posedge CLK) begin
    if (RST || !active || state_r == otrn_pkg::OTRN_IDLE) begin
      per_r <= 8'h00;
    end else if (close_int) begin
      per_r <= 8'h00;
    end else if (CMD_PULSE) begin
      per_r <= per_r + 8'h01;
    end
  end

  // oscillator cycle counter, saturating
  always_ff @(posedge CLK) begin
    if (RST || state_r == otrn_pkg::OTRN_IDLE) begin
      cyc_r <= {{(MEAS_W-1){1'b0}}, 1'b1};
    end else if (close_int) begin
      cyc_r <= {{(MEAS_W-1){1'b0}}, 1'b1};
    end else if (cyc_r != '1) begin
      cyc_r <= cyc_r + 1'b1;
    end
  end

  // measured count captured at the closing command
  always_ff @(posedge CLK) begin
    if (RST) begin
      meas_r <= '0;
    end else if (close_int) begin
      meas_r <= cyc_r;
    end
  end

  // close_int registered so the comparator sees the stored count
  logic cmp_go_r;
  always_ff @(posedge CLK) begin
    if (RST) begin
      cmp_go_r <= 1'b0;
    end else begin
      cmp_go_r <= close_int;
    end
  end

  otrn_cmp #(
    .W(MEAS_W),
    .WIN(WIN),
    .DEAD(DEAD)
  ) u_cmp (
    .clk(CLK),
    .rst(RST),
    .start(cmp_go_r),
    .meas(meas_r),
    .expct(exp_w),
    .done(cmp_done),
    .in_win(cmp_win),
    .go_up(cmp_up),
    .go_down(cmp_dn)
  );

  ////////////////////////////////////////////////////////////////////
  // pending adjustment waits for the end of blocking time
  always_ff @(posedge CLK) begin
    if (RST || !cfg_r[otrn_pkg::EN_BIT]) begin
      pend_r <= 1'b0;
      pend_up_r <= 1'b0;
    end else if (cmp_done && cmp_win && (cmp_up || cmp_dn)) begin
      pend_r <= 1'b1;
      pend_up_r <= cmp_up;
    end else if (BLOCK_END) begin
      pend_r <= 1'b0;
    end
  end

  // training has begun once an interval opened under enable
  always_ff @(posedge CLK) begin
    if (RST) begin
      began_r <= 1'b0;
      en_d_r <= 1'b0;
    end else begin
      en_d_r <= cfg_r[otrn_pkg::EN_BIT];
      if (state_r == otrn_pkg::OTRN_RUN) begin
        began_r <= 1'b1;
      end else if (!cfg_r[otrn_pkg::EN_BIT] && en_d_r) begin
        began_r <= 1'b0;
      end
    end
  end

  // frequency target offset, saturating at the signed range
  always_ff @(posedge CLK) begin
    if (RST) begin
      trim_r <= '0;
    end else if (en_d_r && !cfg_r[otrn_pkg::EN_BIT] && began_r) begin
      if (cfg_r[otrn_pkg::REV_BIT]) begin
        trim_r <= '0;
      end
      // revert clear: hold last value
    end else if (pend_r && BLOCK_END) begin
      trim_r <= trim_nxt;
    end
  end

  // one step up or down; the ends of the signed range hold
  // so a long run of one sign cannot wrap around
  always_comb begin
    trim_nxt = trim_r;
    if (pend_up_r) begin
      if (trim_r <= trim_hi - step_s) begin
        trim_nxt = trim_r + step_s;
      end
    end else if (trim_r >= trim_lo + step_s) begin
      trim_nxt = trim_r - step_s;
    end
  end

  assign TRIM_OFFSET = trim_r;

  ////////////////////////////////////////////////////////////////////
  // up/down failure filter
  always_ff @(posedge CLK) begin
    if (RST) begin
      err_r <= 7'h00;
    end else if (cmp_done && cfg_r[otrn_pkg::EN_BIT]) begin
      if (!cmp_win && err_r != otrn_pkg::ERR_MAX) begin
        err_r <= err_r + 7'h01;
      end else if (cmp_win && err_r != 7'h00) begin
        err_r <= err_r - 7'h01;
      end
    end
  end

  // failure flag latches once the filter reaches its threshold
  always_ff @(posedge CLK) begin
    if (RST) begin
      fail_r <= 1'b0;
    end else if (err_r >= otrn_pkg::ERR_SET) begin
      fail_r <= 1'b1;
    end else if (rd && PADDR == otrn_pkg::STAT_OFF) begin
      fail_r <= 1'b0;
    end
  end

  assign TRIM_FAIL = fail_r;

  ////////////////////////////////////////////////////////////////////
  // events into the status register
  always_comb begin
    ev = '0;
    ev[otrn_pkg::EV_MEAS] = cmp_done;
    ev[otrn_pkg::EV_ADJ] = pend_r && BLOCK_END;
    ev[otrn_pkg::EV_FAIL] = (err_r >= otrn_pkg::ERR_SET) && !fail_r;
  end
endmodule
`default_nettype wire

//--- sim/otrn_top_monitor.sv
// Purpose: port checker for the oscillator trim block
// Assumes: one clock, synchronous reset, zero-wait apb
// Notes: attached to otrn_top by the bind at the foot
`timescale 1ns/1ns
`default_nettype none
module otrn_top_monitor #(
  parameter int STEP = 1,
  parameter int TRIM_W = 8
) (
  input wire logic CLK, // clock
  input wire logic RST, // reset, high
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb access
  input wire logic PWRITE, // apb write
  input wire logic [7:0] PADDR, // apb address
  input wire logic [31:0] PWDATA, // apb write data
  input wire logic PREADY, // apb ready
  input wire logic PSLVERR, // apb error
  input wire logic BLOCK_END, // blocking time end
  input wire logic signed [TRIM_W-1:0] TRIM_OFFSET, // trim target
  input wire logic TRIM_FAIL // failure flag
);
  ////////////////////////////////////////////////////////////////////////////
  // shared clocking and reset for every check
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  ////////////////////////////////////////////////////////////////////////////
  a_ready_const: assert property (PREADY)
    else $error("ready dropped");
  a_err_unmapped: assert property (PSEL && PENABLE && !(PADDR inside {8'h00, 8'h04,
    8'h08, 8'h0C, 8'h10}) |-> PSLVERR) else $error("unmapped access not flagged");
  a_err_idle: assert property (!(PSEL && PENABLE) |-> !PSLVERR)
    else $error("error outside access");
  a_trim_cause: assert property ($changed(TRIM_OFFSET) |->
    $past(BLOCK_END) || $past(PSEL && PENABLE && PWRITE, 2)) else $error("trim moved alone");
  a_trim_step: assert property ($changed(TRIM_OFFSET) && $past(BLOCK_END) |->
    (TRIM_OFFSET - $past(TRIM_OFFSET) == STEP) || (TRIM_OFFSET - $past(TRIM_OFFSET) == -STEP))
    else $error("trim step size wrong");
  a_trim_hold: assert property (PSEL && PENABLE && PWRITE && PADDR == 8'h00 &&
    PWDATA[1:0] == 2'h0 |-> ##2 $stable(TRIM_OFFSET)) else $error("trim lost on disable");
  a_trim_revert: assert property (PSEL && PENABLE && PWRITE && PADDR == 8'h00 &&
    PWDATA[1:0] == 2'h2 |-> ##2 TRIM_OFFSET == 0) else $error("trim not reverted");
  a_fail_sticky: assert property ($fell(TRIM_FAIL) |->
    $past(PSEL && PENABLE && !PWRITE && PADDR == 8'h04)) else $error("flag fell alone");
endmodule
bind otrn_top otrn_top_monitor #(.STEP(STEP), .TRIM_W(TRIM_W)) u_otrn_top_monitor (
  .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .BLOCK_END(BLOCK_END),
  .TRIM_OFFSET(TRIM_OFFSET), .TRIM_FAIL(TRIM_FAIL));
`default_nettype wire

//--- sim/otrn_master_model.sv
// Purpose: bus master sending evenly spaced commands
// Assumes: gap of at least 6 cycles
// Notes: blocking time ends 5 cycles after each command
`timescale 1ns/1ns
`default_nettype none
module otrn_master_model (
  input wire logic clk, // clock
  input wire logic go, // start a burst
  input wire logic [15:0] gap, // cycles between commands
  input wire logic [15:0] num, // commands in the burst
  output logic cmd_pulse, // command marker
  output logic block_end, // end of blocking time
  output logic busy // burst running
);
  ////////////////////////////////////////////////////////////////////////////
  // steady spacing, no spread spectrum on the command timing
  initial begin
    cmd_pulse = 1'b0;
    block_end = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge clk);
      if (go) begin
        busy <= 1'b1;
        for (int i = 0; i < num; i++) begin
          cmd_pulse <= 1'b1;
          @(posedge clk) cmd_pulse <= 1'b0;
          repeat (4) @(posedge clk);
          block_end <= 1'b1;
          @(posedge clk) block_end <= 1'b0;
          repeat (gap - 16'h6) @(posedge clk);
        end
        busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

//--- sim/otrn_tb_top.sv
// Purpose: self-checking bench for the oscillator trim block
// Assumes: training interval shortened to 400 cycles
// Notes: apb reads queue their expectation for a watcher
`timescale 1ns/1ns
`default_nettype none
module otrn_tb_top;
  localparam int EXP = 400;
  localparam int WIN = 20;
  localparam int DEAD = 2;
  logic CLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic PERIODIC_MODE = 1'b0, PROTO_PSI5 = 1'b0, go = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA;
  logic PREADY, PSLVERR, CMD_PULSE, BLOCK_END, IRQ, TRIM_FAIL, busy;
  logic [15:0] gap = 16'h0, num = 16'h0;
  logic signed [7:0] TRIM_OFFSET;
  int fails = 0, total_checks = 0, cyc = 0, seed = 62;
  logic [31:0] exp_q[$];
  string nm_q[$];
  int r_per[6] = '{0, 1, 1, 0, 0, 0};
  int r_code[6] = '{0, 1, 0, 3, 0, 3};
  int r_gap[6] = '{49, 51, 25, 395, 60, 500};
  int r_n[6] = '{2, 1, 1, 1, 1, 63};
  ////////////////////////////////////////////////////////////////////////////
  always #50 CLK = ~CLK;
  otrn_top #(.EXP_CYC(EXP), .WIN(WIN), .DEAD(DEAD)) u_otrn_top (.CLK(CLK), .RST(RST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .CMD_PULSE(CMD_PULSE),
    .BLOCK_END(BLOCK_END), .PERIODIC_MODE(PERIODIC_MODE), .PROTO_PSI5(PROTO_PSI5),
    .TRIM_OFFSET(TRIM_OFFSET), .TRIM_FAIL(TRIM_FAIL), .IRQ(IRQ));
  otrn_master_model u_otrn_master_model (.clk(CLK), .go(go), .gap(gap), .num(num),
    .cmd_pulse(CMD_PULSE), .block_end(BLOCK_END), .busy(busy));
  ////////////////////////////////////////////////////////////////////////////
  // compare, apb transfer and burst helpers
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK) PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1) @(posedge CLK);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    exp_q.push_back(e);
    nm_q.push_back(nm);
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic burst(input int g, input int n);
    gap <= 16'(g);
    num <= 16'(n);
    go <= 1'b1;
    @(posedge CLK) go <= 1'b0;
    @(posedge CLK);
    while (busy !== 1'b0) @(posedge CLK);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // read watcher and hang limit
  always @(posedge CLK) begin
    cyc++;
    if (PSEL && PENABLE && PREADY && !PWRITE && exp_q.size() > 0) begin
      chk(nm_q.pop_front(), PRDATA, exp_q.pop_front());
    end
    if (cyc == 60000) begin
      fails++;
      test_done;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // main sequence: reset values, training table, revert controls
  initial begin
    int us, np, meas, dlt, filt, trim;
    logic fl, f0, inw;
    logic [31:0] cfgv;
    filt = 0;
    trim = 0;
    repeat (4) @(posedge CLK);
    RST <= 1'b0;
    xfer(1'b1, otrn_pkg::TRIM_OFF, $random(seed));
    rd(otrn_pkg::CFG_OFF, 32'h0, "cfg");
    rd(otrn_pkg::MASK_OFF, 32'h0, "mask");
    rd(otrn_pkg::TRIM_OFF, 32'h0, "trim_ro");
    rd(8'h14, 32'h0, "hole");
    xfer(1'b1, otrn_pkg::MASK_OFF, 32'h2);
    for (int r = 0; r < 6; r++) begin
      us = r_per[r] ? otrn_pkg::PERIODIC_COLLECTION_MODE_US[r_code[r]] : otrn_pkg::CRM_US[r_code[r]];
      np = otrn_pkg::TRAIN_US / us;
      meas = r_gap[r] * np;
      inw = (meas >= EXP - WIN) && (meas <= EXP + WIN);
      dlt = !inw ? 0 : (meas > EXP + DEAD) ? -1 : (meas < EXP - DEAD) ? 1 : 0;
      f0 = filt >= 64;
      for (int i = 0; i < r_n[r]; i++) begin
        filt = inw ? (filt > 0 ? filt - 1 : 0) : (filt < 127 ? filt + 1 : 127);
      end
      fl = filt >= 64;
      trim = trim + dlt * r_n[r];
      cfgv = r_per[r] ? ((r_code[r] << 4) | 1) : ((r_code[r] << 2) | 1);
      xfer(1'b1, otrn_pkg::CFG_OFF, 32'h0);
      PERIODIC_MODE <= r_per[r][0];
      PROTO_PSI5 <= r_per[r][0] & 1'($random(seed));
      xfer(1'b1, otrn_pkg::CFG_OFF, {$random(seed)} & 32'hFFFFFF80 | cfgv);
      rd(otrn_pkg::CFG_OFF, cfgv, "cfg_rb");
      burst(r_gap[r], 1 + r_n[r] * np);
      chk("irq", {31'h0, IRQ}, {31'h0, dlt != 0});
      chk("fail", {31'h0, TRIM_FAIL}, {31'h0, fl});
      rd(otrn_pkg::MEAS_OFF, meas, "meas");
      rd(otrn_pkg::TRIM_OFF, {17'h0, 7'(filt), 8'(trim)}, "trim");
      rd(otrn_pkg::STAT_OFF, {29'h0, !f0 && fl, dlt != 0, 1'b1}, "stat");
      chk("irq_clr", {31'h0, IRQ}, 32'h0);
      $display("row %0d done", r);
    end
    xfer(1'b1, otrn_pkg::CFG_OFF, 32'h0);
    @(posedge CLK);
    chk("hold", {24'h0, TRIM_OFFSET}, {24'h0, 8'(trim)});
    xfer(1'b1, otrn_pkg::CFG_OFF, 32'h3);
    burst(50, 1);
    xfer(1'b1, otrn_pkg::CFG_OFF, 32'h2);
    @(posedge CLK);
    chk("revert", {24'h0, TRIM_OFFSET}, 32'h0);
    $display("revert done");
    test_done;
  end
endmodule
`default_nettype wire
